/* File: hdl/acs_pkg.sv */
// Shared constants and types of the channel sequencer
package acs_pkg;

  // ==========================================
  // Bus and timing
  localparam int BUS_W = 12;
  localparam int CTRL_W = 9;
  localparam int CONV_PERIODS = 13;
  localparam logic [3:0] CONV_COUNT = 4'(CONV_PERIODS);
  localparam logic [3:0] ABORT_HALF_PERIODS = 4'(CONV_PERIODS - 1);

  // ==========================================
  // Reset values and masks
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [2:0] CHAN_RESET = 3'h0;
  localparam logic [7:0] PAIR_MASK = 8'h55;

  // ==========================================
  // Enumerations
  typedef enum logic [1:0] {
    CFG_SINGLE = 2'b00,
    CFG_PSEUDO1 = 2'b01,
    CFG_DIFF = 2'b10,
    CFG_PSEUDO2 = 2'b11
  } acs_cfg_t;

  typedef enum logic [1:0] {
    SEQ_OFF = 2'b00,
    SEQ_SELECT = 2'b01,
    SEQ_RANGE = 2'b10
  } acs_seq_t;

  // ==========================================
  // Control word, low bits of the data bus
  typedef struct packed {
    logic [1:0] power;
    logic [2:0] chan_addr;
    acs_cfg_t cfg;
    logic chain_mode_bit;
    logic alternate_register_bit;
  } acs_ctrl_t;

  // Conversion status bundle
  typedef struct packed {
    logic busy;
    logic done;
    logic abort;
    logic [2:0] channel;
  } acs_conv_t;

endpackage

/* File: hdl/acs_conv_timer.sv */
// Conversion period counter with completion and abort pulses
`timescale 1ns/1ps
`default_nettype none
module acs_conv_timer (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic clk_fall_i,
  output logic busy_o,
  output logic done_o,
  output logic abort_o,
  output logic [3:0] periods_o
);

  // ==========================================
  // Counter
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic abort_reg, abort_next;
  logic [3:0] cnt_reg, cnt_next;

  always_comb begin
    busy_next = busy_reg;
    cnt_next = cnt_reg;
    done_next = 1'b0;
    abort_next = 1'b0;
    if (start_i) begin
      abort_next = busy_reg;
      busy_next = 1'b1;
      cnt_next = 4'h0;
    end else if (busy_reg && clk_fall_i) begin
      cnt_next = cnt_reg + 4'h1;
      if (cnt_next == acs_pkg::CONV_COUNT) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      abort_reg <= 1'b0;
      cnt_reg <= 4'h0;
    end else begin
      busy_reg <= busy_next;
      done_reg <= done_next;
      abort_reg <= abort_next;
      cnt_reg <= cnt_next;
    end
  end

  assign busy_o = busy_reg;
  assign done_o = done_reg;
  assign abort_o = abort_reg;
  assign periods_o = cnt_reg;

  // ==========================================
  // Checks
  a_done_full_periods: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    done_o |-> $past(busy_reg) && periods_o == acs_pkg::CONV_COUNT)
    else $error("result valid without thirteen periods");

  a_abort_early: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    start_i && busy_reg |=> abort_o && !done_o && periods_o == 4'h0)
    else $error("short conversion not abandoned");

endmodule
`default_nettype wire

/* File: hdl/acs_chan_pick.sv */
// Next enabled channel finder, ascending with wrap
`timescale 1ns/1ps
`default_nettype none
module acs_chan_pick (
  input wire logic [7:0] mask_i,
  input wire logic [2:0] cur_i,
  input wire logic restart_i,
  output logic found_o,
  output logic [2:0] chan_o
);

  // ==========================================
  // Lowest set bit at or above a floor
  function automatic logic [3:0] lowest_from(input logic [7:0] m, input logic [3:0] lo);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i] && (4'(i) >= lo)) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  logic [3:0] above;
  logic [3:0] wrap;

  always_comb begin
    above = lowest_from(mask_i, restart_i ? 4'h0 : {1'b0, cur_i} + 4'h1);
    wrap = lowest_from(mask_i, 4'h0);
    if (above[3]) begin
      found_o = 1'b1;
      chan_o = above[2:0];
    end else begin
      found_o = wrap[3];
      chan_o = wrap[2:0];
    end
  end

endmodule
`default_nettype wire

/* File: hdl/acs_channel_sequencer.sv */
// Channel sequencer and conversion control of the converter
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - A conversion ends with a valid result only after thirteen full conversion-clock periods.
// - A conversion that gets fewer than thirteen periods before the next start is abandoned.
// - The channel-select register is eight bits and cannot be read back.
// - The low eight data bits load the channel-select register on the write strobe rising edge.
// - That load happens only if the previous control write had chain 0 and alternate 1.
// - Bit n of the channel-select register enables input n.
// - Each start edge converts the next selected channel upward from the lowest, wrapping round.
// - The sequence runs until a control write with chain and alternate other than 1,0.
// - In pair modes only the normal polarity of each pair is sequenced; the address field can select either polarity.
// - With chain 0 and alternate 0 each conversion uses the address field of the last write.
// - A write with chain 1 and alternate 0 updates other fields and leaves the sequence running.
// - With chain 1 and alternate 1 channels 0 up to the address field are converted in turn.
// - The two configuration bits choose single-ended or paired input arrangements.
module acs_channel_sequencer (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic wr_n_i,
  input wire logic [acs_pkg::BUS_W-1:0] data_bus_i,
  input wire logic conversion_start_n_i,
  input wire logic conversion_clock_i,
  output acs_pkg::acs_conv_t conv_o,
  output logic [1:0] power_mode_o,
  output acs_pkg::acs_cfg_t input_config_o,
  output acs_pkg::acs_seq_t seq_mode_o,
  output logic reprogram_hazard_o
);

  // ==========================================
  // Edge detection
  logic wr_n_q_reg, wr_n_q_next;
  logic start_n_q_reg, start_n_q_next;
  logic clk_q_reg, clk_q_next;
  logic wr_rise, start_fall, start_rise, clk_fall;

  always_comb begin
    wr_n_q_next = wr_n_i;
    start_n_q_next = conversion_start_n_i;
    clk_q_next = conversion_clock_i;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_n_q_reg <= 1'b1;
      start_n_q_reg <= 1'b1;
      clk_q_reg <= 1'b0;
    end else begin
      wr_n_q_reg <= wr_n_q_next;
      start_n_q_reg <= start_n_q_next;
      clk_q_reg <= clk_q_next;
    end
  end

  assign wr_rise = !wr_n_q_reg && wr_n_i;
  assign start_fall = start_n_q_reg && !conversion_start_n_i;
  assign start_rise = !start_n_q_reg && conversion_start_n_i;
  assign clk_fall = clk_q_reg && !conversion_clock_i;

  // ==========================================
  // Conversion timing
  logic tmr_busy, tmr_done, tmr_abort;
  logic [3:0] tmr_periods;

  acs_conv_timer u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .start_i(start_fall),
    .clk_fall_i(clk_fall),
    .busy_o(tmr_busy),
    .done_o(tmr_done),
    .abort_o(tmr_abort),
    .periods_o(tmr_periods)
  );

  // ==========================================
  // Control and channel-select registers
  acs_pkg::acs_ctrl_t ctrl_reg, ctrl_next, wr_word;
  logic [7:0] sel_reg, sel_next;
  logic load_pend_reg, load_pend_next;
  acs_pkg::acs_seq_t seq_reg, seq_next;
  logic [2:0] range_last_reg, range_last_next;
  logic restart_reg, restart_next;
  logic [2:0] cur_reg, cur_next;
  logic [2:0] conv_ch_reg, conv_ch_next;
  logic hazard_reg, hazard_next;
  logic keep_seq;

  assign wr_word = acs_pkg::acs_ctrl_t'(data_bus_i[acs_pkg::CTRL_W-1:0]);
  assign keep_seq = wr_word.chain_mode_bit && !wr_word.alternate_register_bit;

  // ==========================================
  // Channel mask
  function automatic logic [7:0] range_mask(input logic [2:0] last);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++) begin
      m[i] = (3'(i) <= last);
    end
    return m;
  endfunction

  logic pair_mode;
  logic [7:0] base_mask, mask;
  logic pick_found;
  logic [2:0] pick_chan;

  always_comb begin
    pair_mode = (ctrl_reg.cfg == acs_pkg::CFG_DIFF) || (ctrl_reg.cfg == acs_pkg::CFG_PSEUDO1);
    if (seq_reg == acs_pkg::SEQ_RANGE) begin
      base_mask = range_mask(range_last_reg);
    end else begin
      base_mask = sel_reg;
    end
    mask = pair_mode ? (base_mask & acs_pkg::PAIR_MASK) : base_mask;
  end

  acs_chan_pick u_pick (
    .mask_i(mask),
    .cur_i(cur_reg),
    .restart_i(restart_reg),
    .found_o(pick_found),
    .chan_o(pick_chan)
  );

  // ==========================================
  // Sequencer next state
  always_comb begin
    ctrl_next = ctrl_reg;
    sel_next = sel_reg;
    load_pend_next = load_pend_reg;
    seq_next = seq_reg;
    range_last_next = range_last_reg;
    restart_next = restart_reg;
    cur_next = cur_reg;
    conv_ch_next = conv_ch_reg;
    hazard_next = hazard_reg;
    if (start_fall) begin
      case (seq_reg)
        acs_pkg::SEQ_SELECT, acs_pkg::SEQ_RANGE: begin
          if (pick_found) begin
            conv_ch_next = pick_chan;
            cur_next = pick_chan;
            restart_next = 1'b0;
          end else begin
            conv_ch_next = ctrl_reg.chan_addr;
          end
        end
        acs_pkg::SEQ_OFF: begin
          conv_ch_next = ctrl_reg.chan_addr;
        end
        default: begin
          conv_ch_next = ctrl_reg.chan_addr;
        end
      endcase
    end
    if (wr_rise) begin
      if (load_pend_reg) begin
        sel_next = data_bus_i[7:0];
        load_pend_next = 1'b0;
        seq_next = acs_pkg::SEQ_SELECT;
        restart_next = 1'b1;
      end else begin
        ctrl_next = wr_word;
        case ({wr_word.chain_mode_bit, wr_word.alternate_register_bit})
          2'b00: begin
            seq_next = acs_pkg::SEQ_OFF;
          end
          2'b01: begin
            seq_next = acs_pkg::SEQ_OFF;
            load_pend_next = 1'b1;
          end
          2'b10: begin
            seq_next = seq_reg;
          end
          2'b11: begin
            seq_next = acs_pkg::SEQ_RANGE;
            range_last_next = wr_word.chan_addr;
            restart_next = 1'b1;
          end
          default: begin
            seq_next = acs_pkg::SEQ_OFF;
          end
        endcase
      end
    end
    if (start_rise || clk_fall) begin
      hazard_next = 1'b0;
    end
    if (start_fall && tmr_busy && tmr_periods == acs_pkg::ABORT_HALF_PERIODS && clk_q_reg) begin
      hazard_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg <= acs_pkg::acs_ctrl_t'(acs_pkg::CTRL_RESET);
      sel_reg <= acs_pkg::SEL_RESET;
      load_pend_reg <= 1'b0;
      seq_reg <= acs_pkg::SEQ_OFF;
      range_last_reg <= acs_pkg::CHAN_RESET;
      restart_reg <= 1'b1;
      cur_reg <= acs_pkg::CHAN_RESET;
      conv_ch_reg <= acs_pkg::CHAN_RESET;
      hazard_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      sel_reg <= sel_next;
      load_pend_reg <= load_pend_next;
      seq_reg <= seq_next;
      range_last_reg <= range_last_next;
      restart_reg <= restart_next;
      cur_reg <= cur_next;
      conv_ch_reg <= conv_ch_next;
      hazard_reg <= hazard_next;
    end
  end

  // ==========================================
  // Outputs
  always_comb begin
    conv_o.busy = tmr_busy;
    conv_o.done = tmr_done;
    conv_o.abort = tmr_abort;
    conv_o.channel = conv_ch_reg;
  end

  assign power_mode_o = ctrl_reg.power;
  assign input_config_o = ctrl_reg.cfg;
  assign seq_mode_o = seq_reg;
  assign reprogram_hazard_o = hazard_reg;

  // ==========================================
  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_sel_write;
    wr_rise && load_pend_reg;
  endsequence

  sequence s_ctrl_write;
    wr_rise && !load_pend_reg;
  endsequence

  sequence s_seq_start;
    start_fall && seq_reg == acs_pkg::SEQ_SELECT && pick_found;
  endsequence

  a_sel_load: assert property (s_sel_write |=> sel_reg == $past(data_bus_i[7:0]))
    else $error("channel select not loaded");

  a_sel_guard: assert property (s_ctrl_write |=> sel_reg == $past(sel_reg))
    else $error("channel select changed by control write");

  a_sel_arms: assert property (s_ctrl_write |=> load_pend_reg ==
    $past(wr_word.alternate_register_bit && !wr_word.chain_mode_bit))
    else $error("select load armed wrongly");

  a_seq_keep: assert property (s_ctrl_write and keep_seq |=> seq_reg == $past(seq_reg))
    else $error("sequence disturbed by hold write");

  a_seq_stop: assert property (s_ctrl_write and !keep_seq |=> seq_reg != acs_pkg::SEQ_SELECT)
    else $error("sequence not stopped");

  a_single_addr: assert property (start_fall && seq_reg == acs_pkg::SEQ_OFF
    |=> conv_ch_reg == $past(ctrl_reg.chan_addr))
    else $error("addressed channel not used");

  a_seq_enabled: assert property (s_seq_start |=> sel_reg[conv_ch_reg] || $past(wr_rise))
    else $error("sequence picked a disabled channel");

  a_pair_polarity: assert property (start_fall && seq_reg != acs_pkg::SEQ_OFF && pair_mode
    && pick_found |=> !conv_ch_reg[0])
    else $error("swapped pair converted");

  a_range_bound: assert property (start_fall && seq_reg == acs_pkg::SEQ_RANGE
    |=> conv_ch_reg <= $past(range_last_reg))
    else $error("range sequence beyond final channel");

endmodule
`default_nettype wire

/* File: dv/acs_host.sv */
// Host model driving the write bus and conversion controls
`timescale 1ns/1ps
`default_nettype none
module acs_host (
  input wire logic sys_clk_i,
  output logic wr_n_o,
  output logic [acs_pkg::BUS_W-1:0] data_bus_o,
  output logic conversion_start_n_o,
  output logic conversion_clock_o
);
  initial begin
    wr_n_o = 1'b1;
    data_bus_o = 12'h000;
    conversion_start_n_o = 1'b1;
    conversion_clock_o = 1'b0;
  end
  // ==========================================
  // Write cycle, data scrambled once taken
  task automatic wr(input logic [acs_pkg::BUS_W-1:0] d);
    @(negedge sys_clk_i);
    wr_n_o = 1'b0;
    data_bus_o = d;
    @(negedge sys_clk_i);
    wr_n_o = 1'b1;
    @(negedge sys_clk_i);
    data_bus_o = ~d;
  endtask
  // ==========================================
  // Conversion clock and start strobe
  task automatic half();
    repeat (3) @(negedge sys_clk_i);
    conversion_clock_o = 1'b1;
  endtask
  task automatic clk_period();
    half();
    repeat (3) @(negedge sys_clk_i);
    conversion_clock_o = 1'b0;
  endtask
  task automatic start_fall();
    @(negedge sys_clk_i);
    conversion_start_n_o = 1'b0;
  endtask
  task automatic start_rise();
    @(negedge sys_clk_i);
    conversion_start_n_o = 1'b1;
  endtask
  task automatic conv(input int n);
    start_fall();
    start_rise();
    repeat (n) clk_period();
  endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench of the channel sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk_i;
  logic rst_i;
  logic wr_n;
  logic [acs_pkg::BUS_W-1:0] db;
  logic cs_n;
  logic cclk;
  acs_pkg::acs_conv_t conv;
  logic [1:0] pw;
  acs_pkg::acs_cfg_t cfg;
  acs_pkg::acs_seq_t seq;
  logic hz;
  int mismatches = 0;
  int comparisons = 0;
  int dn = 0;
  int ab = 0;
  int a0;
  int d0;
  logic [15:0] rnd;
  logic [2:0] e_addr;
  logic [2:0] e_last;
  logic [7:0] e_mask;
  logic [1:0] e_cfg;
  logic [1:0] e_mode;
  logic e_rs;
  acs_host u_host (.sys_clk_i(sys_clk_i), .wr_n_o(wr_n), .data_bus_o(db),
    .conversion_start_n_o(cs_n), .conversion_clock_o(cclk));
  acs_channel_sequencer u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .wr_n_i(wr_n),
    .data_bus_i(db), .conversion_start_n_i(cs_n), .conversion_clock_i(cclk),
    .conv_o(conv), .power_mode_o(pw), .input_config_o(cfg), .seq_mode_o(seq),
    .reprogram_hazard_o(hz));
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  always @(negedge sys_clk_i) begin
    dn += (conv.done === 1'b1);
    ab += (conv.abort === 1'b1);
  end
  // ==========================================
  // Checking and expectation helpers
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [7:0] eff(input logic [7:0] m, input logic [1:0] c);
    return (c == 2'b01 || c == 2'b10) ? (m & acs_pkg::PAIR_MASK) : m;
  endfunction
  function automatic logic [2:0] pick(input logic [7:0] m, input logic [2:0] l,
    input logic rs, input logic [2:0] a);
    logic [2:0] r;
    r = a;
    for (int i = 7; i >= 0; i--) if (m[i]) r = 3'(i);
    if (!rs) for (int i = 7; i > l; i--) if (m[i]) r = 3'(i);
    return r;
  endfunction
  task automatic ctl(input logic [2:0] a, input logic [1:0] c, input logic ch,
    input logic al);
    rnd = lfsr(rnd);
    u_host.wr({rnd[2:0], rnd[4:3], a, c, ch, al});
    e_addr = a;
    e_cfg = c;
    if (ch && al) begin
      e_mode = 2'h2;
      e_mask = 8'((9'h002 << a) - 9'h001);
      e_rs = 1'b1;
    end else if (!ch) begin
      e_mode = 2'h0;
    end
    @(negedge sys_clk_i);
    chk("power", {6'h00, rnd[4:3]}, {6'h00, pw});
    chk("config", {6'h00, c}, {6'h00, cfg});
    chk("seq", {6'h00, e_mode}, {6'h00, seq});
  endtask
  task automatic sel(input logic [7:0] m);
    rnd = lfsr(rnd);
    u_host.wr({rnd[3:0], m});
    e_mask = m;
    e_mode = 2'h1;
    e_rs = 1'b1;
    @(negedge sys_clk_i);
    chk("seq", 8'h01, {6'h00, seq});
  endtask
  task automatic run();
    logic [2:0] ch;
    int k;
    ch = (e_mode == 2'h0) ? e_addr : pick(eff(e_mask, e_cfg), e_last, e_rs, e_addr);
    e_last = ch;
    e_rs = 1'b0;
    d0 = dn;
    u_host.conv(13);
    k = 0;
    while (dn == d0 && k < 8) begin
      @(negedge sys_clk_i);
      k++;
    end
    chk("done", 8'h01, 8'(dn - d0));
    chk("busy", 8'h00, {7'h00, conv.busy});
    chk("channel", {5'h00, ch}, {5'h00, conv.channel});
  endtask
  // ==========================================
  // Main sequence
  initial begin
    logic [7:0] m;
    rst_i = 1'b1;
    rnd = 16'h734F;
    e_last = 3'h0;
    e_rs = 1'b1;
    e_mode = 2'h0;
    repeat (20) @(negedge sys_clk_i);
    rst_i = 1'b0;
    @(negedge sys_clk_i);
    chk("seq", 8'h00, {6'h00, seq});
    chk("conv", 8'h00, {2'h0, conv});
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      ctl(rnd[7:5], 2'(i), 1'b0, 1'b0);
      run();
    end
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      m = (i == 0) ? 8'h81 : rnd[7:0];
      if (rnd[9:8] == 2'b01 || rnd[9:8] == 2'b10) m = (m & 8'h55) | ((m & 8'h55) << 1);
      ctl(rnd[12:10], rnd[9:8], 1'b0, 1'b1);
      sel(m);
      repeat (3) run();
      ctl(rnd[15:13], e_cfg, 1'b1, 1'b0);
      repeat (4) run();
    end
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      ctl((i == 0) ? 3'h7 : rnd[2:0], rnd[4:3], 1'b1, 1'b1);
      repeat (3) run();
      ctl(rnd[7:5], e_cfg, 1'b1, 1'b0);
      repeat (3) run();
    end
    ctl(3'h5, 2'b00, 1'b0, 1'b0);
    a0 = ab;
    d0 = dn;
    u_host.conv(12);
    u_host.half();
    u_host.start_fall();
    repeat (3) @(negedge sys_clk_i);
    chk("abort", 8'h01, 8'(ab - a0));
    chk("done", 8'h00, 8'(dn - d0));
    chk("hazard", 8'h01, {7'h00, hz});
    u_host.start_rise();
    repeat (2) @(negedge sys_clk_i);
    chk("hazard", 8'h00, {7'h00, hz});
    run();
    ctl(3'h2, 2'b00, 1'b0, 1'b1);
    sel(8'hF0);
    rst_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    rst_i = 1'b0;
    @(negedge sys_clk_i);
    chk("seq", 8'h00, {6'h00, seq});
    chk("conv", 8'h00, {2'h0, conv});
    conclude();
  end
  initial begin
    #2500000;
    mismatches++;
    conclude();
  end
endmodule
`default_nettype wire
